/* File: core/rrs_pkg.sv */
// constants, types and register map of the receive restart and sequencer block
package rrs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_RX_CFG = 4'h0;
  localparam logic [3:0] OFF_GAIN = 4'h1;
  localparam logic [3:0] OFF_AUTO = 4'h2;
  localparam logic [3:0] OFF_LEVEL = 4'h3;
  localparam logic [3:0] OFF_SEQ = 4'h4;
  localparam logic [3:0] OFF_OPMODE = 4'h5;
  localparam logic [3:0] OFF_T1 = 4'h6;
  localparam logic [3:0] OFF_T2 = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  // sequencer control and auto restart wait field positions
  localparam int SEQ_LAUNCH_BIT = 7;
  localparam int SEQ_STOP_BIT = 6;
  localparam int SEQ_REST_BIT = 5;
  localparam int SEQ_LPSEL_BIT = 4;
  localparam int SEQ_FROM_IDLE_BIT = 3;
  localparam int AUTO_WAIT_LSB = 4;
  // chip modes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam logic [2:0] OPMODE_RESET = 3'h1;
  // receive trigger codes
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_RSSI = 3'h1;
  localparam logic [2:0] TRIG_PRE = 3'h6;
  localparam logic [2:0] TRIG_BOTH = 3'h7;
  // automatic restart selections
  localparam logic [1:0] AR_OFF = 2'h0;
  localparam logic [1:0] AR_WAIT = 2'h1;
  localparam logic [1:0] AR_RELOCK = 2'h2;
  // timing
  localparam int CLK_NS = 20;
  localparam int PLL_LOCK_NS = 20000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int IPD_STEP_NS = 2000;
  localparam int IPD_STEP_CYC = (IPD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_STEP_NS = 1000;
  localparam int TIMER_STEP_CYC = (TIMER_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int EVAL_BASE_NS = 2000;
  localparam int EVAL_BASE_CYC = (EVAL_BASE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    SEQ_HALTED, SEQ_IDLE, SEQ_TX, SEQ_RX, SEQ_FRAME_HELD, SEQ_POWER_CHOICE, SEQ_EXPIRY
  } rrs_seq_e;
  typedef struct packed {
    logic collision_restart_enable;
    logic restart_keep_oscillator;
    logic restart_relock_oscillator;
    logic auto_freq_correct_enable;
    logic auto_gain_enable;
    logic [2:0] receive_trigger_select;
  } rrs_rx_cfg_s;
  typedef struct packed {
    logic on_strength;
    logic on_preamble;
    logic on_sync;
  } rrs_timeouts_s;
endpackage

/* File: core/rrs_core.sv */
// receive restart control, gain/frequency correction start and mode sequencer
//
// How it works
// (RULE_01) strength sample ready after evaluation time
// (RULE_02) corrections armed on receiver start and restarts
// (RULE_03) trigger code picks event; enables gate corrections
// (RULE_04) agc off means manual amplifier gain
// (RULE_05) keep-oscillator restart only without frequency change
// (RULE_06) relock restart after frequency or correction change
// (RULE_07) user restart ignored unless mode settled
// (RULE_08) restart select 00 never restarts itself
// (RULE_09) select 01 restarts after empty plus wait
// (RULE_10) select 10 adds oscillator lock delay
// (RULE_11) collision restart on sudden strength rise
// (RULE_12) rise compared to threshold in dB steps
// (RULE_13) sequencer works only in FSK/OOK mode
// (RULE_14) launch from sleep/standby records initial mode
// (RULE_15) stop forces sequencer off anytime
// (RULE_16) launch and stop never written together
// (RULE_17) halted waits; from choice restores initial mode
// (RULE_18) idle holds rest mode, waits first timer
// (RULE_19) transmit, receive, frame-held keep radio on
// (RULE_20) power choice picks halted or idle
// (RULE_21) any of three timeouts is expiry
// (RULE_22) two timers drive sequencer mode changes
// (RULE_23) rest choice 0 standby, 1 sleep
// (RULE_24) power select 0 halted, 1 idle
// (RULE_25) trigger bits self-clear after one action
`timescale 1ns/1ps
`default_nettype none
module rrs_core #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [rrs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rrs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rrs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic fsk_mode,
  input wire logic mode_settled_flag,
  input wire logic payload_complete_event,
  input wire logic buffer_empty,
  input wire logic packet_sent,
  input wire logic [7:0] rssi_value,
  input wire logic rssi_valid,
  input wire logic rssi_irq,
  input wire logic preamble_found_event,
  input wire rrs_pkg::rrs_timeouts_s timeouts,
  input wire logic [2:0] agc_gain,
  output logic [2:0] chip_mode,
  output logic [2:0] amp_gain,
  output logic agc_run,
  output logic afc_run,
  output logic rx_restart,
  output logic relock_osc,
  output logic strength_ready,
  output logic receive_expiry_event
);
  rrs_pkg::rrs_rx_cfg_s rx_cfg_ff;
  rrs_pkg::rrs_seq_e seq_ff;
  logic [2:0] manual_amp_gain_ff;
  logic [1:0] auto_receive_restart_sel_ff;
  logic [3:0] between_packet_wait_ff;
  logic [2:0] strength_averaging_option_ff;
  logic [7:0] collision_level_step_ff;
  logic rest_power_choice_ff, lp_sel_ff, from_idle_ff;
  logic [2:0] op_mode_ff, init_mode_ff, chip_mode_ff, amp_gain_ff;
  logic [7:0] t1_reload_ff, t2_reload_ff, t1_cnt_ff, t2_cnt_ff;
  logic launch_req_ff, stop_req_ff, keep_req_ff, relock_req_ff;
  logic [7:0] rdata_ff, rssi_prev_ff;
  logic prev_ok_ff, armed_ff, agc_run_ff, afc_run_ff, rx_restart_ff, relock_ff;
  logic ar_pend_ff, ar_dly_on_ff, ar_relock_ff, eval_done_ff, expiry_ff, was_rx_ff;
  logic [CNT_W-1:0] ar_dly_ff, eval_cnt_ff, nxt_eval_load, nxt_ar_load;
  logic [7:0] pre_cnt_ff;
  logic tick, rx_on, user_go, auto_go, coll_go, seq_go, restart_go, any_timeout;
  logic t1_fire, t2_fire, wr_seq, trig_hit;
  logic [2:0] nxt_chip_mode;

  // evaluation time is twice the base, doubled again for each step of the averaging option up to 6; option 7 gives the base alone
  function automatic logic [CNT_W-1:0] eval_cycles(input logic [2:0] avg);
    eval_cycles = CNT_W'(rrs_pkg::EVAL_BASE_CYC) << (avg + 3'h1);
  endfunction

  // trigger decode; unused codes act as no trigger
  function automatic logic trig_decode(input logic [2:0] sel, input logic rs, input logic pr);
    case (sel)
      rrs_pkg::TRIG_RSSI: trig_decode = rs;
      rrs_pkg::TRIG_PRE: trig_decode = pr;
      rrs_pkg::TRIG_BOTH: trig_decode = rs | pr;
      default: trig_decode = 1'b0;
    endcase
  endfunction

  assign wr_seq = reg_wr && (reg_addr == rrs_pkg::OFF_SEQ);
  assign rx_on = (chip_mode_ff == rrs_pkg::MODE_RX);
  assign any_timeout = timeouts.on_strength | timeouts.on_preamble | timeouts.on_sync; // RULE_21
  assign trig_hit = trig_decode(rx_cfg_ff.receive_trigger_select, rssi_irq,
                                preamble_found_event); // RULE_03
  // the controller picks keep or relock; both restart alike, and relock also pulses relock_osc
  assign user_go = (keep_req_ff | relock_req_ff) && mode_settled_flag && rx_on; // RULE_07 RULE_05
  assign auto_go = ar_dly_on_ff && (ar_dly_ff == '0); // RULE_09
  assign coll_go = rx_cfg_ff.collision_restart_enable && rx_on && rssi_valid && prev_ok_ff
                   && (rssi_value > rssi_prev_ff)
                   && ((rssi_value - rssi_prev_ff) >= collision_level_step_ff); // RULE_11 RULE_12
  assign seq_go = (seq_ff == rrs_pkg::SEQ_EXPIRY);
  assign restart_go = user_go | auto_go | coll_go | seq_go; // RULE_02
  assign nxt_eval_load = eval_cycles(strength_averaging_option_ff);
  assign nxt_ar_load = CNT_W'(between_packet_wait_ff) * CNT_W'(rrs_pkg::IPD_STEP_CYC)
    + ((auto_receive_restart_sel_ff == rrs_pkg::AR_RELOCK) ? CNT_W'(rrs_pkg::PLL_LOCK_CYC)
       : CNT_W'(0)); // RULE_10

  // shared prescaler for the sequencer timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_ff <= 8'h00;
    end else if (pre_cnt_ff == 8'(rrs_pkg::TIMER_STEP_CYC - 1)) begin
      pre_cnt_ff <= 8'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 8'h01;
    end
  end
  assign tick = (pre_cnt_ff == 8'(rrs_pkg::TIMER_STEP_CYC - 1));
  assign t1_fire = (seq_ff == rrs_pkg::SEQ_IDLE) && tick && (t1_cnt_ff <= 8'h01); // RULE_22
  assign t2_fire = (seq_ff == rrs_pkg::SEQ_RX) && tick && (t2_cnt_ff <= 8'h01); // RULE_22

  // timers reload outside their state, count steps inside it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t1_cnt_ff <= 8'h00;
      t2_cnt_ff <= 8'h00;
    end else begin
      if (seq_ff != rrs_pkg::SEQ_IDLE || t1_fire) begin
        t1_cnt_ff <= t1_reload_ff;
      end else if (tick) begin
        t1_cnt_ff <= t1_cnt_ff - 8'h01;
      end
      if (seq_ff != rrs_pkg::SEQ_RX || t2_fire) begin
        t2_cnt_ff <= t2_reload_ff;
      end else if (tick) begin
        t2_cnt_ff <= t2_cnt_ff - 8'h01;
      end
    end
  end

  // register writes; op mode also restored when power choice sends the sequencer to halted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_cfg_ff <= '0;
      manual_amp_gain_ff <= 3'h0;
      auto_receive_restart_sel_ff <= 2'h0;
      between_packet_wait_ff <= 4'h0;
      strength_averaging_option_ff <= 3'h0;
      collision_level_step_ff <= 8'h0A;
      rest_power_choice_ff <= 1'b0;
      lp_sel_ff <= 1'b0;
      from_idle_ff <= 1'b0;
      op_mode_ff <= rrs_pkg::OPMODE_RESET;
      t1_reload_ff <= 8'h00;
      t2_reload_ff <= 8'h00;
    end else begin
      if (seq_ff == rrs_pkg::SEQ_POWER_CHOICE && !lp_sel_ff) begin
        op_mode_ff <= init_mode_ff; // RULE_17
      end else if (reg_wr && reg_addr == rrs_pkg::OFF_OPMODE) begin
        op_mode_ff <= reg_wdata[2:0];
      end
      if (reg_wr) begin
        case (reg_addr)
          rrs_pkg::OFF_RX_CFG: begin
            rx_cfg_ff <= reg_wdata;
          end
          rrs_pkg::OFF_GAIN: begin
            manual_amp_gain_ff <= reg_wdata[2:0];
            strength_averaging_option_ff <= reg_wdata[6:4];
          end
          rrs_pkg::OFF_AUTO: begin
            auto_receive_restart_sel_ff <= reg_wdata[1:0];
            between_packet_wait_ff <= reg_wdata[rrs_pkg::AUTO_WAIT_LSB +: 4];
          end
          rrs_pkg::OFF_LEVEL: collision_level_step_ff <= reg_wdata;
          rrs_pkg::OFF_SEQ: begin
            rest_power_choice_ff <= reg_wdata[rrs_pkg::SEQ_REST_BIT];
            lp_sel_ff <= reg_wdata[rrs_pkg::SEQ_LPSEL_BIT];
            from_idle_ff <= reg_wdata[rrs_pkg::SEQ_FROM_IDLE_BIT];
          end
          rrs_pkg::OFF_T1: t1_reload_ff <= reg_wdata;
          rrs_pkg::OFF_T2: t2_reload_ff <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // trigger bits live one cycle and never read back as set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      launch_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      keep_req_ff <= 1'b0;
      relock_req_ff <= 1'b0;
    end else begin
      launch_req_ff <= wr_seq && reg_wdata[rrs_pkg::SEQ_LAUNCH_BIT]; // RULE_25
      stop_req_ff <= wr_seq && reg_wdata[rrs_pkg::SEQ_STOP_BIT]; // RULE_25
      keep_req_ff <= reg_wr && reg_addr == rrs_pkg::OFF_RX_CFG && reg_wdata[6]; // RULE_25
      relock_req_ff <= reg_wr && reg_addr == rrs_pkg::OFF_RX_CFG && reg_wdata[5]; // RULE_25
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        rrs_pkg::OFF_RX_CFG: rdata_ff <= {rx_cfg_ff[7], 2'b00, rx_cfg_ff[4:0]};
        rrs_pkg::OFF_GAIN: rdata_ff <= {1'b0, strength_averaging_option_ff, 1'b0,
                                        manual_amp_gain_ff};
        rrs_pkg::OFF_AUTO: rdata_ff <= {between_packet_wait_ff, 2'b00,
                                        auto_receive_restart_sel_ff};
        rrs_pkg::OFF_LEVEL: rdata_ff <= collision_level_step_ff;
        rrs_pkg::OFF_SEQ: rdata_ff <= {2'b00, rest_power_choice_ff, lp_sel_ff, from_idle_ff,
                                       3'b000};
        rrs_pkg::OFF_OPMODE: rdata_ff <= {5'h00, op_mode_ff};
        rrs_pkg::OFF_T1: rdata_ff <= t1_reload_ff;
        rrs_pkg::OFF_T2: rdata_ff <= t2_reload_ff;
        rrs_pkg::OFF_STATUS: rdata_ff <= {seq_ff, mode_settled_flag, ar_pend_ff, chip_mode_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // sequencer; stop and loss of FSK/OOK mode override every state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_ff <= rrs_pkg::SEQ_HALTED;
      init_mode_ff <= rrs_pkg::MODE_STDBY;
    end else if (stop_req_ff || !fsk_mode) begin
      seq_ff <= rrs_pkg::SEQ_HALTED; // RULE_15 RULE_13 RULE_16
    end else begin
      case (seq_ff)
        rrs_pkg::SEQ_HALTED: begin
          if (launch_req_ff && (op_mode_ff == rrs_pkg::MODE_SLEEP
              || op_mode_ff == rrs_pkg::MODE_STDBY)) begin
            seq_ff <= rrs_pkg::SEQ_POWER_CHOICE; // RULE_14
            init_mode_ff <= op_mode_ff; // RULE_14
          end
        end
        rrs_pkg::SEQ_POWER_CHOICE: begin
          seq_ff <= lp_sel_ff ? rrs_pkg::SEQ_IDLE : rrs_pkg::SEQ_HALTED; // RULE_20 RULE_24
        end
        rrs_pkg::SEQ_IDLE: begin
          if (t1_fire) begin
            seq_ff <= from_idle_ff ? rrs_pkg::SEQ_RX : rrs_pkg::SEQ_TX; // RULE_18
          end
        end
        rrs_pkg::SEQ_TX: begin
          if (packet_sent) begin
            seq_ff <= rrs_pkg::SEQ_POWER_CHOICE;
          end
        end
        rrs_pkg::SEQ_RX: begin
          if (t2_fire) begin
            seq_ff <= rrs_pkg::SEQ_POWER_CHOICE;
          end else if (payload_complete_event) begin
            seq_ff <= rrs_pkg::SEQ_FRAME_HELD;
          end else if (any_timeout) begin
            seq_ff <= rrs_pkg::SEQ_EXPIRY; // RULE_21
          end
        end
        rrs_pkg::SEQ_FRAME_HELD: begin
          if (buffer_empty) begin
            seq_ff <= rrs_pkg::SEQ_POWER_CHOICE;
          end
        end
        rrs_pkg::SEQ_EXPIRY: seq_ff <= rrs_pkg::SEQ_RX;
        default: seq_ff <= rrs_pkg::SEQ_HALTED;
      endcase
    end
  end

  // chip mode follows the sequencer while it runs, else the op mode register
  always_comb begin
    case (seq_ff)
      rrs_pkg::SEQ_IDLE: nxt_chip_mode = rest_power_choice_ff ? rrs_pkg::MODE_SLEEP
                                         : rrs_pkg::MODE_STDBY; // RULE_18 RULE_23
      rrs_pkg::SEQ_TX: nxt_chip_mode = rrs_pkg::MODE_TX; // RULE_19
      rrs_pkg::SEQ_RX, rrs_pkg::SEQ_FRAME_HELD, rrs_pkg::SEQ_EXPIRY:
        nxt_chip_mode = rrs_pkg::MODE_RX; // RULE_19
      rrs_pkg::SEQ_POWER_CHOICE: nxt_chip_mode = init_mode_ff;
      default: nxt_chip_mode = op_mode_ff; // RULE_17
    endcase
  end

  // mode and gain outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chip_mode_ff <= rrs_pkg::OPMODE_RESET;
      amp_gain_ff <= 3'h0;
      was_rx_ff <= 1'b0;
    end else begin
      chip_mode_ff <= nxt_chip_mode;
      was_rx_ff <= rx_on;
      amp_gain_ff <= rx_cfg_ff.auto_gain_enable ? agc_gain : manual_amp_gain_ff; // RULE_04
    end
  end

  // corrections armed at receiver start or restart, fired by the trigger event
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed_ff <= 1'b0;
      agc_run_ff <= 1'b0;
      afc_run_ff <= 1'b0;
    end else begin
      agc_run_ff <= armed_ff && trig_hit && rx_cfg_ff.auto_gain_enable; // RULE_03
      afc_run_ff <= armed_ff && trig_hit && rx_cfg_ff.auto_gain_enable
                    && rx_cfg_ff.auto_freq_correct_enable; // RULE_03
      // a restart in the firing cycle rearms, so the next packet is not skipped
      if ((rx_on && !was_rx_ff) || restart_go) begin
        armed_ff <= 1'b1; // RULE_02
      end else if (trig_hit || !rx_on) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // restart strobes; relock for user relock request or select 10
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_restart_ff <= 1'b0;
      relock_ff <= 1'b0;
      expiry_ff <= 1'b0;
    end else begin
      rx_restart_ff <= restart_go;
      relock_ff <= (user_go && relock_req_ff) || (auto_go && ar_relock_ff); // RULE_06
      expiry_ff <= any_timeout && rx_on;
    end
  end

  // automatic restart: pending on payload, wait for empty buffer, then delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ar_pend_ff <= 1'b0;
      ar_dly_on_ff <= 1'b0;
      ar_relock_ff <= 1'b0;
      ar_dly_ff <= '0;
    end else begin
      if (payload_complete_event && rx_on
          && auto_receive_restart_sel_ff != rrs_pkg::AR_OFF) begin
        ar_pend_ff <= 1'b1; // RULE_08
      end else if (ar_pend_ff && buffer_empty) begin
        ar_pend_ff <= 1'b0;
      end
      if (ar_pend_ff && buffer_empty && !payload_complete_event) begin
        ar_dly_on_ff <= 1'b1; // RULE_09
        ar_dly_ff <= nxt_ar_load; // RULE_10
        ar_relock_ff <= (auto_receive_restart_sel_ff == rrs_pkg::AR_RELOCK);
      end else if (auto_go || !rx_on) begin
        ar_dly_on_ff <= 1'b0;
      end else if (ar_dly_on_ff) begin
        ar_dly_ff <= ar_dly_ff - CNT_W'(1);
      end
    end
  end

  // strength sample timing and collision reference
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eval_cnt_ff <= '0;
      eval_done_ff <= 1'b0;
      rssi_prev_ff <= 8'h00;
      prev_ok_ff <= 1'b0;
    end else begin
      if (restart_go || !rx_on || !mode_settled_flag) begin
        eval_cnt_ff <= nxt_eval_load;
        eval_done_ff <= 1'b0;
      end else if (eval_cnt_ff != '0) begin
        eval_cnt_ff <= eval_cnt_ff - CNT_W'(1);
      end else begin
        eval_done_ff <= 1'b1; // RULE_01
      end
      if (restart_go || !rx_on) begin
        prev_ok_ff <= 1'b0;
      end else if (rssi_valid) begin
        rssi_prev_ff <= rssi_value;
        prev_ok_ff <= 1'b1;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign chip_mode = chip_mode_ff;
  assign amp_gain = amp_gain_ff;
  assign agc_run = agc_run_ff;
  assign afc_run = afc_run_ff;
  assign rx_restart = rx_restart_ff;
  assign relock_osc = relock_ff;
  assign strength_ready = eval_done_ff;
  assign receive_expiry_event = expiry_ff;

  // checks
  property p_settled;
    @(posedge clk) disable iff (!resetn)
    (keep_req_ff && !mode_settled_flag && !auto_go && !coll_go && !seq_go) |=> !rx_restart_ff;
  endproperty
  a_settled: assert property (p_settled) else $error("restart taken while not settled"); // RULE_07
  property p_gain;
    @(posedge clk) disable iff (!resetn)
    !rx_cfg_ff.auto_gain_enable |=> (amp_gain == $past(manual_amp_gain_ff));
  endproperty
  a_gain: assert property (p_gain) else $error("manual gain not applied"); // RULE_04
  property p_stop;
    @(posedge clk) disable iff (!resetn)
    stop_req_ff |=> (seq_ff == rrs_pkg::SEQ_HALTED) ##1 (seq_ff == rrs_pkg::SEQ_HALTED
      || seq_ff == rrs_pkg::SEQ_POWER_CHOICE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt sequencer"); // RULE_15
  property p_launch;
    @(posedge clk) disable iff (!resetn)
    (launch_req_ff && !stop_req_ff && fsk_mode && seq_ff == rrs_pkg::SEQ_HALTED
     && (op_mode_ff == rrs_pkg::MODE_SLEEP || op_mode_ff == rrs_pkg::MODE_STDBY))
     |=> (seq_ff == rrs_pkg::SEQ_POWER_CHOICE) && (init_mode_ff == $past(op_mode_ff));
  endproperty
  a_launch: assert property (p_launch) else $error("launch not taken"); // RULE_14
  property p_fsk;
    @(posedge clk) disable iff (!resetn)
    !fsk_mode |=> (seq_ff == rrs_pkg::SEQ_HALTED);
  endproperty
  a_fsk: assert property (p_fsk) else $error("sequencer ran outside fsk mode"); // RULE_13
  property p_trig_none;
    @(posedge clk) disable iff (!resetn)
    (rx_cfg_ff.receive_trigger_select == rrs_pkg::TRIG_NONE) |=> !agc_run_ff;
  endproperty
  a_trig_none: assert property (p_trig_none) else $error("correction without trigger"); // RULE_03
  property p_afc_needs_agc;
    @(posedge clk) disable iff (!resetn)
    afc_run_ff |-> agc_run_ff;
  endproperty
  a_afc_needs_agc: assert property (p_afc_needs_agc) else $error("afc alone"); // RULE_03
  property p_coll;
    @(posedge clk) disable iff (!resetn)
    coll_go |=> rx_restart_ff && armed_ff;
  endproperty
  a_coll: assert property (p_coll) else $error("collision restart missing"); // RULE_11
  property p_ar_off;
    @(posedge clk) disable iff (!resetn)
    (auto_receive_restart_sel_ff == rrs_pkg::AR_OFF && !ar_pend_ff && !ar_dly_on_ff) |=> !auto_go;
  endproperty
  a_ar_off: assert property (p_ar_off) else $error("auto restart while off"); // RULE_08
  property p_idle;
    @(posedge clk) disable iff (!resetn)
    (seq_ff == rrs_pkg::SEQ_IDLE) |=> (chip_mode_ff == ($past(rest_power_choice_ff)
      ? rrs_pkg::MODE_SLEEP : rrs_pkg::MODE_STDBY));
  endproperty
  a_idle: assert property (p_idle) else $error("idle mode wrong"); // RULE_18
  c_user: cover property (@(posedge clk) disable iff (!resetn) user_go ##1 rx_restart_ff);
  c_auto: cover property (@(posedge clk) disable iff (!resetn) auto_go && ar_relock_ff);
  c_seq: cover property (@(posedge clk) disable iff (!resetn)
    seq_ff == rrs_pkg::SEQ_IDLE ##1 seq_ff == rrs_pkg::SEQ_RX);
endmodule // rrs_core
`default_nettype wire

/* File: verif/rrs_radio_model.sv */
// radio-side responder that reports mode settling and buffer state
`timescale 1ns/1ps
`default_nettype none
module rrs_radio_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] chip_mode,
  output logic mode_settled_flag,
  output logic buffer_empty
);
  logic [2:0] last_ff;
  // settled only once the mode has stood still for a cycle, never at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_ff <= 3'h1;
      mode_settled_flag <= 1'b0;
    end else begin
      last_ff <= chip_mode;
      mode_settled_flag <= (last_ff == chip_mode);
    end
  end
  assign buffer_empty = 1'b1; // reader drains at once
endmodule // rrs_radio_model
`default_nettype wire

/* File: verif/rrs_core_bench.sv */
// self-checking bench for the receive restart and sequencer core
`timescale 1ns/1ps
`default_nettype none
module rrs_core_bench;
  logic clk, resetn, reg_wr, reg_rd, fsk_mode, settled, bempty, rssi_valid, rx_restart;
  logic relock_osc, agc_run, afc_run, expiry, sready, irq, pre, pay;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rssi_value, d, v;
  logic [2:0] agc_gain, chip_mode, amp_gain, tmo;
  int n_fail, compares, seed, n, r, g, f, x;
  rrs_core rrs_core_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fsk_mode(fsk_mode), .mode_settled_flag(settled), .payload_complete_event(pay),
    .buffer_empty(bempty), .packet_sent(1'b0), .rssi_value(rssi_value),
    .rssi_valid(rssi_valid), .rssi_irq(irq), .preamble_found_event(pre),
    .timeouts(tmo), .agc_gain(agc_gain), .chip_mode(chip_mode), .amp_gain(amp_gain),
    .agc_run(agc_run), .afc_run(afc_run), .rx_restart(rx_restart), .relock_osc(relock_osc),
    .strength_ready(sready), .receive_expiry_event(expiry));
  rrs_radio_model rrs_radio_model_inst (.clk(clk), .resetn(resetn), .chip_mode(chip_mode),
    .mode_settled_flag(settled), .buffer_empty(bempty));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
    // one idle edge, so back-to-back writes never set the strobe twice in a step
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // output pulses seen over k cycles, sampled mid-cycle where settled
  task automatic pulses(input int k);
    n = 0;
    r = 0;
    g = 0;
    f = 0;
    x = 0;
    repeat (k) begin
      @(negedge clk);
      n += (rx_restart === 1'b1);
      r += (relock_osc === 1'b1);
      g += (agc_run === 1'b1);
      f += (afc_run === 1'b1);
      x += (expiry === 1'b1);
    end
    // back on a rising edge, so the next stimulus starts there
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is under two thousand cycles; this bound is generous
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    {resetn, reg_wr, reg_rd, fsk_mode, rssi_valid} = 5'b00010;
    {reg_addr, reg_wdata, rssi_value, agc_gain} = 23'h0;
    {irq, pre, pay, tmo} = 6'h00;
    seed = 32'h0f960dae;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("mode", {5'h0, chip_mode}, {5'h0, rrs_pkg::MODE_STDBY});
    rd(rrs_pkg::OFF_LEVEL);
    chk("level", d, 8'h0A);
    rd(4'hF);
    chk("unmapped", d, 8'h00);
    wr(rrs_pkg::OFF_GAIN, 8'h05);
    repeat (2) @(posedge clk);
    chk("gain", {5'h0, amp_gain}, 8'h05);
    $display("test reset and gain done");
    fsk_mode <= 1'b0;
    wr(rrs_pkg::OFF_SEQ, 8'hB0);
    repeat (6) @(posedge clk);
    rd(rrs_pkg::OFF_STATUS);
    chk("state", {5'h0, d[7:5]}, 8'h00);
    fsk_mode <= 1'b1;
    wr(rrs_pkg::OFF_SEQ, 8'hB0);
    repeat (6) @(posedge clk);
    chk("mode", {5'h0, chip_mode}, {5'h0, rrs_pkg::MODE_SLEEP});
    rd(rrs_pkg::OFF_STATUS);
    chk("state", {5'h0, d[7:5]}, 8'h01);
    wr(rrs_pkg::OFF_SEQ, 8'h40);
    repeat (4) @(posedge clk);
    rd(rrs_pkg::OFF_STATUS);
    chk("state", {5'h0, d[7:5]}, 8'h00);
    $display("test sequencer done");
    wr(rrs_pkg::OFF_OPMODE, {5'h0, rrs_pkg::MODE_RX});
    repeat (4) @(posedge clk);
    wr(rrs_pkg::OFF_RX_CFG, 8'h40);
    pulses(6);
    chk("restart", n[7:0], 8'h01);
    chk("relock", r[7:0], 8'h00);
    wr(rrs_pkg::OFF_RX_CFG, 8'h80);
    wr(rrs_pkg::OFF_LEVEL, 8'h05);
    rssi_value <= 8'd10;
    rssi_valid <= 1'b1;
    @(posedge clk);
    rssi_value <= 8'd16;
    @(posedge clk);
    rssi_valid <= 1'b0;
    pulses(6);
    chk("collision", n[7:0], 8'h01);
    wr(rrs_pkg::OFF_RX_CFG, 8'h20);
    pulses(6);
    chk("relock", r[7:0], 8'h01);
    chk("ready", {7'h0, sready}, 8'h00);
    repeat (2 * rrs_pkg::EVAL_BASE_CYC) @(posedge clk);
    chk("ready", {7'h0, sready}, 8'h01);
    $display("test restart done");
    // strength event must not fire under preamble-only trigger
    wr(rrs_pkg::OFF_RX_CFG, 8'h1E);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    pulses(6);
    chk("agc", g[7:0], 8'h01);
    chk("afc", f[7:0], 8'h01);
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    pulses(6);
    chk("agc again", g[7:0], 8'h00);
    $display("test corrections done");
    pay <= 1'b1;
    @(posedge clk);
    pay <= 1'b0;
    pulses(30);
    chk("auto off", n[7:0], 8'h00);
    wr(rrs_pkg::OFF_AUTO, {6'h00, rrs_pkg::AR_RELOCK});
    pay <= 1'b1;
    @(posedge clk);
    pay <= 1'b0;
    pulses(rrs_pkg::PLL_LOCK_CYC - 10);
    chk("early", n[7:0], 8'h00);
    pulses(20);
    chk("auto", n[7:0], 8'h01);
    chk("auto relock", r[7:0], 8'h01);
    // launch into idle standby, first timer leads to receive
    wr(rrs_pkg::OFF_T2, 8'hFF);
    wr(rrs_pkg::OFF_T1, 8'h02);
    wr(rrs_pkg::OFF_OPMODE, {5'h0, rrs_pkg::MODE_STDBY});
    wr(rrs_pkg::OFF_SEQ, 8'h98);
    repeat (3 * rrs_pkg::TIMER_STEP_CYC) @(posedge clk);
    chk("seq rx", {5'h0, chip_mode}, {5'h0, rrs_pkg::MODE_RX});
    tmo <= 3'b100;
    @(posedge clk);
    tmo <= 3'b000;
    pulses(6);
    chk("expiry", x[7:0], 8'h01);
    chk("seq restart", n[7:0], 8'h01);
    wr(rrs_pkg::OFF_SEQ, 8'h40);
    $display("test auto and sequencer done");
    repeat (20) begin
      v = $random(seed);
      agc_gain <= v[2:0];
      wr(rrs_pkg::OFF_LEVEL, v);
      rd(rrs_pkg::OFF_LEVEL);
      chk("level", d, v);
    end
    $display("test random done");
    end_sim();
  end
endmodule // rrs_core_bench
`default_nettype wire
